/* File: sim/rx_status_monitor.sv */
// Checker: port-level assertions for the receive-status and FIFO sizing block
`timescale 1ns/1ps
module rx_status_monitor #(
  parameter int QUEUE_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic host_role,
  input wire rx_status_pkg::rx_event_t rx_event,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic event_ready,
  input wire logic queue_not_empty,
  input wire logic [15:0] rx_fifo_word_depth,
  input wire logic [15:0] tx_fifo_start,
  input wire logic [15:0] tx_fifo_depth,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Code accepted in the role in force; reserved codes never reach the queue
  wire logic legal = host_role ? (rx_event.packet_status inside {4'h2, 4'h3, 4'h5, 4'h7})
    : (rx_event.packet_status inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6});
  a_depth_reset_value: assert property (
    $fell(reset) |-> rx_fifo_word_depth == 16'h0200 && tx_fifo_start == 16'h0200)
    else $error("Sizing field not at reset value");
  a_rx_depth_write: assert property (
    reg_wr && reg_addr == 8'h24 |=> rx_fifo_word_depth == 16'($past(reg_wdata)))
    else $error("Receive depth not taken from write");
  a_tx_cfg_write: assert property (
    reg_wr && reg_addr == 8'h28 |=> {tx_fifo_depth, tx_fifo_start} == $past(reg_wdata))
    else $error("Transmit configuration not taken from write");
  a_idle_rdata_zero: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("Read data present without a read");
  a_push_shows_entry: assert property (
    rx_event.valid && event_ready && legal |=> queue_not_empty)
    else $error("Accepted event not queued");
  a_reserved_dropped: assert property (
    rx_event.valid && !legal && !queue_not_empty |=> !queue_not_empty)
    else $error("Reserved code was queued");
  a_peek_keeps_entry: assert property (
    reg_rd && reg_addr == 8'h1C && queue_not_empty |=> queue_not_empty)
    else $error("Peek removed an entry");
  a_cfg_read_back: assert property (
    reg_rd && reg_addr == 8'h28 |=> reg_rdata == {$past(tx_fifo_depth), $past(tx_fifo_start)})
    else $error("Transmit configuration read mismatch");
endmodule : rx_status_monitor
bind rx_status_fifo_cfg rx_status_monitor #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_monitor (
  .clk_sys(clk_sys), .reset(reset), .host_role(host_role), .rx_event(rx_event),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .event_ready(event_ready), .queue_not_empty(queue_not_empty),
  .rx_fifo_word_depth(rx_fifo_word_depth), .tx_fifo_start(tx_fifo_start),
  .tx_fifo_depth(tx_fifo_depth), .irq(irq));

/* File: sim/tb_rx_status_fifo_cfg.sv */
// Self-checking bench for the receive-status and FIFO sizing block
`timescale 1ns/1ps
module tb_rx_status_fifo_cfg;
  logic clk_sys = 1'b0, reset = 1'b1, host_role = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rd_seen = 1'b0, irq, event_ready, queue_not_empty;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v, w;
  logic [31:0] exp_q[$], ent_q[$];
  logic [15:0] rx_fifo_word_depth, tx_fifo_start, tx_fifo_depth;
  logic [3:0] dev_codes[6] = '{4'h5, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
  logic [3:0] hst_codes[5] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'h1};
  rx_status_pkg::rx_event_t rx_event;
  int errors = 0, checks_done = 0, seed = 32'h19aa;
  usb_event_source u_src (.clk_sys(clk_sys), .rx_event(rx_event));
  rx_status_fifo_cfg u_dut (.clk_sys(clk_sys), .reset(reset), .host_role(host_role),
    .rx_event(rx_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_ready(event_ready),
    .queue_not_empty(queue_not_empty), .rx_fifo_word_depth(rx_fifo_word_depth),
    .tx_fifo_start(tx_fifo_start), .tx_fifo_depth(tx_fifo_depth), .irq(irq));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Bus cycles end with a free cycle so no strobe is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  // Read data stand only in the cycle after the strobe, so compare right there
  always @(posedge clk_sys) begin
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  // Sends a random event and notes the word it should leave in the current role
  task automatic ev(input logic [3:0] sts, input logic [1:0] pid, input bit keep);
    v = $random(seed);
    w = {7'h00, host_role ? 4'h0 : v[27:24], sts, pid, v[14:4], v[3:0]};
    u_src.send(v[3:0], v[14:4], pid, sts, v[27:24]);
    if (keep) ent_q.push_back(w);
  endtask : ev
  task automatic drain(input int n);
    for (int i = 0; i < n; i++) rd(8'h20, ent_q.pop_front());
  endtask : drain
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(8'h24, 32'h0000_0200);
    rd(8'h28, 32'h0000_0200);
    rd(8'h10, 32'h0);
    rd(8'h20, 32'h0);
    $display("Test reset values done");
    // Only the low half of the receive depth is kept; with legal depths the range flag stays clear after the clear write
    v = $random(seed);
    wr(8'h24, {v[31:16], 16'h0100});
    rd(8'h24, 32'h0000_0100);
    wr(8'h28, {16'h0100, v[15:0]});
    rd(8'h28, {16'h0100, v[15:0]});
    check({16'h0, tx_fifo_start}, {16'h0, v[15:0]});
    check({16'h0, tx_fifo_depth}, 32'h0000_0100);
    check({16'h0, rx_fifo_word_depth}, 32'h0000_0100);
    wr(8'h44, 32'h7);
    rd(8'h40, 32'h0);
    wr(8'h48, 32'h1);
    $display("Test sizing done");
    // Device role: a reserved code on an empty queue, then every legal code
    for (int i = 0; i < 6; i++) ev(dev_codes[i], i[1:0], i > 0);
    check({31'h0, irq}, 32'h1);
    rd(8'h1C, ent_q[0]);
    drain(5);
    rd(8'h20, 32'h0);
    check({31'h0, queue_not_empty}, 32'h0);
    host_role <= 1'b1;
    wr(8'h44, 32'h7);
    check({31'h0, irq}, 32'h0);
    $display("Test device role done");
    // Host role overfills the queue; the entry past the depth is dropped
    for (int i = 0; i < 11; i++) ev(hst_codes[i % 5], i[1:0], i % 5 != 4 && i < 10);
    check({31'h0, event_ready}, 32'h0);
    check({31'h0, queue_not_empty}, 32'h1);
    rd(8'h4C, 32'h0000_0008);
    rd(8'h40, 32'h3);
    wr(8'h48, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(8'h48, 32'h2);
    check({31'h0, irq}, 32'h1);
    drain(8);
    wr(8'h44, 32'h7);
    check({31'h0, irq}, 32'h0);
    // A depth legal for the host transmit FIFO is out of range once the role turns to device
    wr(8'h28, 32'h0200_0000);
    wr(8'h44, 32'h7);
    rd(8'h40, 32'h0);
    host_role <= 1'b0;
    @(posedge clk_sys);
    rd(8'h40, 32'h4);
    $display("Test host role done");
    print_verdict();
  end
  // Watchdog: the sequence needs well under 400 cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end
endmodule : tb_rx_status_fifo_cfg

/* File: sim/usb_event_source.sv */
// Model of the far-side packet engine that reports received packets and events
`timescale 1ns/1ps
module usb_event_source (
  input wire logic clk_sys,
  output rx_status_pkg::rx_event_t rx_event
);
  initial rx_event = '0;
  // One-cycle event in bus order; fields are inverted after it so stale values never match
  task automatic send(input logic [3:0] idx, input logic [10:0] bc, input logic [1:0] pid,
      input logic [3:0] sts, input logic [3:0] fr);
    rx_event <= {1'b1, idx, bc, pid, sts, fr};
    @(posedge clk_sys);
    rx_event <= {1'b0, ~rx_event[24:0]};
    @(posedge clk_sys);
  endtask : send
endmodule : usb_event_source

/* File: src/rx_status_fifo_cfg.sv */
// Receive-status queue, FIFO sizing registers and interrupt logic of the USB OTG core
//
// Overview of operation
// RULE1: Host role: bits 3:0 carry the channel the data arrived on.
// RULE2: Host role: bits 14:4 carry the received IN packet byte count.
// RULE3: Host role: PID field DATA0=00, DATA1=10, DATA2=01, MDATA=11.
// RULE4: Host role: status 0010 is IN data, 0011 is IN transfer complete.
// RULE5: Host role: status 0101 toggle error, 0111 channel halted, others reserved.
// RULE6: Device role: bits 3:0 carry the addressed endpoint number.
// RULE7: Device role: bits 14:4 carry the received packet byte count.
// RULE8: Device role: PID field DATA0=00, DATA2=01, DATA1=10, MDATA=11.
// RULE9: Device role: 0001 global OUT NAK, 0010 OUT data, 0011 OUT done.
// RULE10: Device role: 0100 SETUP done, 0110 SETUP data, others reserved.
// RULE11: Device role: bits 24:21 hold low frame number bits.
// RULE12: Status readable at peek offset without pop, and at pop offset with pop.
// RULE13: Receive FIFO depth is 16 bits in words, legal 16 to 1024.
// RULE14: Host role: low half is non-periodic transmit FIFO start address.
// RULE15: Host role: high half is non-periodic transmit depth, 16 to 1024.
// RULE16: Device role: low half is endpoint-zero transmit FIFO start address.
// RULE17: Device role: high half is endpoint-zero transmit depth, 16 to 256.
// RULE18: Status and transmit fields take meaning from current host or device role.
// RULE19: Entries queue in bus order; oldest is presented first.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module rx_status_fifo_cfg #(
  parameter int QUEUE_DEPTH = 8,
  parameter int ISO_OUT_SUPPORTED = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic host_role,
  input wire rx_status_pkg::rx_event_t rx_event,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic event_ready,
  output logic queue_not_empty,
  output logic [15:0] rx_fifo_word_depth,
  output logic [15:0] tx_fifo_start,
  output logic [15:0] tx_fifo_depth,
  output logic irq
);
  localparam int PTR_W = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
  localparam int CNT_W = $clog2(QUEUE_DEPTH + 1);

  // Elaboration check: the queue needs at least two entries and a power-of-two size
  if (QUEUE_DEPTH < 2 || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("QUEUE_DEPTH must be a power of two of at least 2");
  end

  // Whole block state
  typedef struct packed {
    rx_status_pkg::rx_status_word_t [QUEUE_DEPTH-1:0] queue;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr;
    logic [CNT_W-1:0] count;
    logic [31:0] rx_fifo_depth;
    logic [31:0] tx_fifo_start_and_depth;
    logic [rx_status_pkg::IRQ_BITS-1:0] irq_status;
    logic [rx_status_pkg::IRQ_BITS-1:0] irq_enable;
    logic [31:0] rdata;
  } state_t;

  state_t cur;
  state_t next_state;

  // Range check shared by the receive and transmit depth fields
  function automatic logic depth_in_range(input logic [15:0] depth, input logic [15:0] max);
    depth_in_range = (depth >= rx_status_pkg::DEPTH_MIN) && (depth <= max);
  endfunction : depth_in_range

  // Build a status word from an event; reserved codes are kept out of the queue
  function automatic rx_status_pkg::rx_status_word_t build_word(
    input rx_status_pkg::rx_event_t ev,
    input logic is_host
  );
    build_word = '0;
    build_word.rx_channel_index = ev.index; // [RULE1] [RULE6]
    build_word.rx_byte_count = ev.byte_count; // [RULE2] [RULE7]
    build_word.rx_data_pid = ev.data_pid; // [RULE3] [RULE8]
    build_word.rx_packet_status = ev.packet_status; // [RULE4] [RULE9]
    // Frame bits only exist in device role with isochronous OUT support
    if (!is_host && ISO_OUT_SUPPORTED != 0) begin
      build_word.rx_frame_low_bits = ev.frame_low; // [RULE11] [RULE18]
    end
  endfunction : build_word

  // Legal packet status codes for each role
  function automatic logic code_legal(input logic [3:0] code, input logic is_host);
    if (is_host) begin
      code_legal = (code == rx_status_pkg::HST_IN_DATA) ||
                   (code == rx_status_pkg::HST_IN_DONE) ||
                   (code == rx_status_pkg::HST_TOGGLE_ERR) ||
                   (code == rx_status_pkg::HST_CH_HALTED); // [RULE4] [RULE5]
    end else begin
      code_legal = (code == rx_status_pkg::DEV_GLOBAL_OUT_NAK) ||
                   (code == rx_status_pkg::DEV_OUT_DATA) ||
                   (code == rx_status_pkg::DEV_OUT_DONE) ||
                   (code == rx_status_pkg::DEV_SETUP_DONE) ||
                   (code == rx_status_pkg::DEV_SETUP_DATA); // [RULE9] [RULE10]
    end
  endfunction : code_legal

  rx_status_pkg::reg_req_t req;
  rx_status_pkg::rx_status_word_t head;
  rx_status_pkg::tx_fifo_view_t tx_view;
  logic do_push;
  logic do_pop;
  logic full;
  logic [15:0] tx_depth_max;
  logic [rx_status_pkg::IRQ_BITS-1:0] irq_events;

  // Bundle the register port
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  assign full = (cur.count == CNT_W'(QUEUE_DEPTH));
  assign head = cur.queue[cur.rd_ptr]; // Oldest entry [RULE19]

  // Pop only on a pop-offset read of a non-empty queue; peek never pops [RULE12]
  assign do_pop = req.rd && (req.addr == rx_status_pkg::OFF_RX_STATUS_POP) && (cur.count != '0);
  // A full queue accepts a push in the same cycle as a pop frees a slot
  assign event_ready = !full || do_pop;
  assign do_push = rx_event.valid && event_ready &&
                   code_legal(rx_event.packet_status, host_role);

  // Transmit configuration seen through the current role [RULE18]
  assign tx_depth_max = host_role ? rx_status_pkg::NP_TX_DEPTH_MAX
                                  : rx_status_pkg::EP0_TX_DEPTH_MAX;
  always_comb begin
    tx_view.start = cur.tx_fifo_start_and_depth[15:0]; // [RULE14] [RULE16]
    tx_view.depth = cur.tx_fifo_start_and_depth[31:16]; // [RULE15] [RULE17]
    tx_view.depth_ok = depth_in_range(tx_view.depth, tx_depth_max); // [RULE15] [RULE17]
  end

  // Interrupt events; an event dropped by a full queue or an illegal depth is worth software attention
  always_comb begin
    irq_events = '0;
    irq_events[rx_status_pkg::IRQ_NOT_EMPTY] = do_push;
    irq_events[rx_status_pkg::IRQ_OVERFLOW] = rx_event.valid && !event_ready;
    irq_events[rx_status_pkg::IRQ_BAD_DEPTH] =
      !tx_view.depth_ok ||
      !depth_in_range(cur.rx_fifo_depth[15:0], rx_status_pkg::RX_DEPTH_MAX); // [RULE13]
  end

  // Next-state logic
  always_comb begin
    next_state = cur;

    // Queue push and pop, in arrival order [RULE19]
    if (do_push) begin
      next_state.queue[cur.wr_ptr] = build_word(rx_event, host_role);
      next_state.wr_ptr = cur.wr_ptr + PTR_W'(1);
    end
    if (do_pop) begin
      next_state.rd_ptr = cur.rd_ptr + PTR_W'(1);
    end
    if (do_push && !do_pop) begin
      next_state.count = cur.count + CNT_W'(1);
    end else if (do_pop && !do_push) begin
      next_state.count = cur.count - CNT_W'(1);
    end

    // Register writes; the depth field is 16 bits, upper half reserved [RULE13]
    if (req.wr) begin
      if (req.addr == rx_status_pkg::OFF_RX_FIFO_DEPTH) begin
        next_state.rx_fifo_depth = {16'h0000, req.wdata[15:0]}; // [RULE13]
      end else if (req.addr == rx_status_pkg::OFF_TX_FIFO_CFG) begin
        next_state.tx_fifo_start_and_depth = req.wdata; // [RULE14] [RULE15]
      end else if (req.addr == rx_status_pkg::OFF_IRQ_ENABLE) begin
        next_state.irq_enable = req.wdata[rx_status_pkg::IRQ_BITS-1:0];
      end
    end

    // Sticky status: clear first, then set, so a same-cycle event survives
    if (req.wr && req.addr == rx_status_pkg::OFF_IRQ_CLEAR) begin
      next_state.irq_status = cur.irq_status & ~req.wdata[rx_status_pkg::IRQ_BITS-1:0];
    end
    next_state.irq_status = next_state.irq_status | irq_events;

    // Read data, valid the cycle after the strobe; unmapped reads give zero
    next_state.rdata = '0;
    if (req.rd) begin
      if (req.addr == rx_status_pkg::OFF_RX_STATUS_PEEK ||
          req.addr == rx_status_pkg::OFF_RX_STATUS_POP) begin
        // Empty queue reads zero rather than a stale entry
        if (cur.count != '0) begin
          next_state.rdata = head; // [RULE12]
        end
      end else if (req.addr == rx_status_pkg::OFF_RX_FIFO_DEPTH) begin
        next_state.rdata = cur.rx_fifo_depth;
      end else if (req.addr == rx_status_pkg::OFF_TX_FIFO_CFG) begin
        next_state.rdata = cur.tx_fifo_start_and_depth;
      end else if (req.addr == rx_status_pkg::OFF_IRQ_STATUS) begin
        next_state.rdata = 32'(cur.irq_status);
      end else if (req.addr == rx_status_pkg::OFF_IRQ_ENABLE) begin
        next_state.rdata = 32'(cur.irq_enable);
      end else if (req.addr == rx_status_pkg::OFF_QUEUE_LEVEL) begin
        next_state.rdata = 32'(cur.count);
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur <= '0;
      cur.rx_fifo_depth <= rx_status_pkg::RST_RX_FIFO_DEPTH;
      cur.tx_fifo_start_and_depth <= rx_status_pkg::RST_TX_FIFO_CFG;
    end else begin
      cur <= next_state;
    end
  end

  // Outputs
  assign reg_rdata = cur.rdata;
  assign queue_not_empty = (cur.count != '0);
  assign rx_fifo_word_depth = cur.rx_fifo_depth[15:0]; // [RULE13]
  assign tx_fifo_start = tx_view.start; // [RULE18]
  assign tx_fifo_depth = tx_view.depth;
  assign irq = |(cur.irq_status & cur.irq_enable);
endmodule : rx_status_fifo_cfg

/* File: src/rx_status_pkg.sv */
// Package: register map, field layout, codes and shared types of the receive-status block
package rx_status_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_RX_STATUS_PEEK = 8'h1C;
  localparam logic [7:0] OFF_RX_STATUS_POP = 8'h20;
  localparam logic [7:0] OFF_RX_FIFO_DEPTH = 8'h24;
  localparam logic [7:0] OFF_TX_FIFO_CFG = 8'h28;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h44;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h48;
  localparam logic [7:0] OFF_QUEUE_LEVEL = 8'h4C;
  // Reset values
  localparam logic [31:0] RST_RX_FIFO_DEPTH = 32'h0000_0200;
  localparam logic [31:0] RST_TX_FIFO_CFG = 32'h0000_0200;
  // Depth limits in 32-bit words
  localparam logic [15:0] DEPTH_MIN = 16'h0010;
  localparam logic [15:0] RX_DEPTH_MAX = 16'h0400;
  localparam logic [15:0] NP_TX_DEPTH_MAX = 16'h0400;
  localparam logic [15:0] EP0_TX_DEPTH_MAX = 16'h0100;
  // Host-role packet status codes
  localparam logic [3:0] HST_IN_DATA = 4'h2;
  localparam logic [3:0] HST_IN_DONE = 4'h3;
  localparam logic [3:0] HST_TOGGLE_ERR = 4'h5;
  localparam logic [3:0] HST_CH_HALTED = 4'h7;
  // Device-role packet status codes
  localparam logic [3:0] DEV_GLOBAL_OUT_NAK = 4'h1;
  localparam logic [3:0] DEV_OUT_DATA = 4'h2;
  localparam logic [3:0] DEV_OUT_DONE = 4'h3;
  localparam logic [3:0] DEV_SETUP_DONE = 4'h4;
  localparam logic [3:0] DEV_SETUP_DATA = 4'h6;
  // Data PID encodings
  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_DATA2 = 2'h1;
  localparam logic [1:0] PID_DATA1 = 2'h2;
  localparam logic [1:0] PID_MDATA = 2'h3;
  // Interrupt bit positions
  localparam int IRQ_NOT_EMPTY = 0;
  localparam int IRQ_OVERFLOW = 1;
  localparam int IRQ_BAD_DEPTH = 2;
  localparam int IRQ_BITS = 3;

  // Receive status word; bits 31:25 are reserved zero
  typedef struct packed {
    logic [6:0] reserved;
    logic [3:0] rx_frame_low_bits;
    logic [3:0] rx_packet_status;
    logic [1:0] rx_data_pid;
    logic [10:0] rx_byte_count;
    logic [3:0] rx_channel_index;
  } rx_status_word_t;

  // Event reported by the packet engine
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [10:0] byte_count;
    logic [1:0] data_pid;
    logic [3:0] packet_status;
    logic [3:0] frame_low;
  } rx_event_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Transmit FIFO configuration in role-specific form
  typedef struct packed {
    logic [15:0] start;
    logic [15:0] depth;
    logic depth_ok;
  } tx_fifo_view_t;
endpackage : rx_status_pkg
